/* design/ast_pkg.sv */
`default_nettype none
package ast_pkg;
  // register byte offsets
  localparam logic [5:0] ADDR_DATA = 6'h00;
  localparam logic [5:0] ADDR_RSR = 6'h04;
  localparam logic [5:0] ADDR_FLAG = 6'h18;
  localparam logic [5:0] ADDR_LPDIV = 6'h20;
  localparam logic [5:0] ADDR_IBRD = 6'h24;
  localparam logic [5:0] ADDR_FBRD = 6'h28;
  localparam logic [5:0] ADDR_LCRH = 6'h2c;
  localparam logic [5:0] ADDR_CTL = 6'h30;
  localparam logic [5:0] ADDR_IFLS = 6'h34;
  // line control fields
  localparam int LCRH_BRK = 0;
  localparam int LCRH_PEN = 1;
  localparam int LCRH_EPS = 2;
  localparam int LCRH_STP2 = 3;
  localparam int LCRH_FEN = 4;
  localparam int LCRH_WLEN = 5;
  localparam int LCRH_SPS = 7;
  // control fields
  localparam int CTL_EN = 0;
  localparam int CTL_SIR = 1;
  localparam int CTL_SIRLP = 2;
  localparam int CTL_TXE = 8;
  localparam int CTL_RXE = 9;
  // flag fields
  localparam int FLAG_BUSY = 3;
  localparam int FLAG_RXFE = 4;
  localparam int FLAG_TXFF = 5;
  localparam int FLAG_RXFF = 6;
  localparam int FLAG_TXFE = 7;
  localparam int FLAG_TXLVL = 8;
  localparam int FLAG_RXLVL = 9;
  // receive entry status fields (also receive status register bits 0..3)
  localparam int ENT_FE = 8;
  localparam int ENT_PE = 9;
  localparam int ENT_BE = 10;
  localparam int ENT_OE = 11;
  // reset values
  localparam logic [9:0] CTL_RESET = 10'h300;
  localparam logic [5:0] IFLS_RESET = 6'h12;
  localparam logic [7:0] LPDIV_RESET = 8'h00;
  // oversampling timing, in oversample ticks; low-power pulse in low-power clock ticks; bus response codes
  localparam logic [3:0] START_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] SIR_PULSE_TICKS = 4'h3;
  localparam logic [1:0] SIR_LP_PULSE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_PAR = 3'h2, TX_STOP = 3'h6
  } ast_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6,
    RX_WAITHI = 3'h7
  } ast_rx_e;
endpackage
`default_nettype wire

/* design/ast_uart.sv */
// Summary of operation
// - frame is start, data lsb first, parity, stop
// - five to eight data bits, both directions
// - even, odd, stick or no parity
// - one or two stop bits sent
// - divisor is 16 integer plus 6 fraction bits
// - divisor yields 16x tick; sixteen ticks per bit
// - divisors and line control latch on line write
// - transmit and receive enables reset to enabled
// - disable lets the current character finish
// - overrun, parity, framing, break stored with character
// - sixteen-entry fifos, receive entries four bits wider
// - fifo can shrink to one-entry holding register
// - fill triggers at eighths of fifo depth
// - fifo write starts frames, back to back
// - busy until fifo empty and shifter done
// - start bit confirmed low at eighth tick
// - data sampled every sixteenth tick, then parity
// - stop must be high, else framing error
// - infrared pulses, 3/16 bit or low power
// - low power pulse clock divides by 1..256
// - fifos disabled after reset
// - data read twelve bits, write eight bits
`default_nettype none
module ast_uart
  import ast_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int ADDR_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in,
  output logic serial_out
);
  localparam int AW = $clog2(FIFO_DEPTH);
  if (FIFO_DEPTH < 8 || (1 << AW) != FIFO_DEPTH || ADDR_W < 6) begin : g_bad_param
    $error("fifo depth must be a power of two >= 8 and address at least 6 bits");
  end

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // true when no address bit above the register map is set
  function automatic logic upper_clear(input logic [ADDR_W-1:0] a);
    return (a >> 6) == '0;
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                   input logic eps, input logic sps);
    logic p;
    p = ^(d & (8'hff >> (2'h3 - wl)));
    if (sps) return !eps;
    return eps ? p : !p;
  endfunction

  function automatic logic [AW:0] level(input logic [2:0] sel, input logic [AW:0] d);
    logic [AW:0] t;
    case (sel)
      3'h0: t = d >> 3;
      3'h1: t = d >> 2;
      3'h2: t = d >> 1;
      3'h3: t = d - (d >> 2);
      default: t = d - (d >> 3);
    endcase
    return (t == '0) ? (AW+1)'(1) : t;
  endfunction

  logic [9:0] ctl;
  logic [7:0] lcrh, lat_lcrh, lpdiv;
  logic [15:0] ibrd;
  logic [5:0] fbrd, ifls;
  logic [21:0] lat_div;
  logic [3:0] rsr;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, wr_hit;
  logic rx_meta, rx_sync;
  logic [15:0] bcnt;
  logic [5:0] bacc;
  logic [6:0] facc_sum;
  logic tick, lp_tick;
  logic [7:0] lpcnt;
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [11:0] rx_mem [FIFO_DEPTH];
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0] tx_count, rx_count, eff_depth;
  logic tx_full, rx_full, tx_push, tx_pop, rx_pop, busy;
  ast_tx_e tx_state;
  logic [7:0] tx_shift;
  logic [2:0] tx_bit;
  logic [3:0] tx_tk;
  logic tx_par, tx_second, tx_line, ir_pulse;
  logic [1:0] ir_lp_cnt;
  ast_rx_e rx_state;
  logic [3:0] rx_tk, sir_hold;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_pe, rx_anyone, rx_line, rx_push, oe_pend;
  logic [11:0] rx_entry;

  // register bus: address and data taken in either order, write one cycle after both
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit = upper_clear(aw_addr) && (aw_addr[5:0] == ADDR_DATA ||
    aw_addr[5:0] == ADDR_RSR || aw_addr[5:0] == ADDR_FLAG || aw_addr[5:0] == ADDR_LPDIV ||
    aw_addr[5:0] == ADDR_IBRD || aw_addr[5:0] == ADDR_FBRD || aw_addr[5:0] == ADDR_LCRH ||
    aw_addr[5:0] == ADDR_CTL || aw_addr[5:0] == ADDR_IFLS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; divisor and line settings reach the logic only on a line write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= CTL_RESET;
      lcrh <= 8'h00;
      lat_lcrh <= 8'h00;
      ibrd <= 16'h0000;
      fbrd <= 6'h00;
      lat_div <= 22'h000000;
      ifls <= IFLS_RESET;
      lpdiv <= LPDIV_RESET;
    end else if (wr_fire && upper_clear(aw_addr)) begin
      case (aw_addr[5:0])
        ADDR_CTL: ctl <= 10'(wmerge({22'h0, ctl}, w_data, w_strb));
        ADDR_IBRD: ibrd <= 16'(wmerge({16'h0, ibrd}, w_data, w_strb));
        ADDR_FBRD: fbrd <= 6'(wmerge({26'h0, fbrd}, w_data, w_strb));
        ADDR_IFLS: ifls <= 6'(wmerge({26'h0, ifls}, w_data, w_strb));
        ADDR_LPDIV: lpdiv <= 8'(wmerge({24'h0, lpdiv}, w_data, w_strb));
        ADDR_LCRH: begin
          lcrh <= 8'(wmerge({24'h0, lcrh}, w_data, w_strb));
          lat_lcrh <= 8'(wmerge({24'h0, lcrh}, w_data, w_strb));
          lat_div <= {ibrd, fbrd};
        end
        default: ;
      endcase
    end
  end

  // read side; a data read pops the receive fifo
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (!upper_clear(s_axi_araddr)) begin
        s_axi_rresp <= RESP_SLVERR;
      end else begin
        case (s_axi_araddr[5:0])
          ADDR_DATA: s_axi_rdata <= rx_count != '0 ? {20'h0, rx_mem[rx_rp]} : 32'h0;
          ADDR_RSR: s_axi_rdata <= {28'h0, rsr};
          ADDR_FLAG: begin
            s_axi_rdata[FLAG_BUSY] <= busy;
            s_axi_rdata[FLAG_RXFE] <= rx_count == '0;
            s_axi_rdata[FLAG_TXFF] <= tx_full;
            s_axi_rdata[FLAG_RXFF] <= rx_full;
            s_axi_rdata[FLAG_TXFE] <= tx_count == '0;
            s_axi_rdata[FLAG_TXLVL] <= tx_count <= level(ifls[2:0], eff_depth);
            s_axi_rdata[FLAG_RXLVL] <= rx_count >= level(ifls[5:3], eff_depth);
          end
          ADDR_LPDIV: s_axi_rdata <= {24'h0, lpdiv};
          ADDR_IBRD: s_axi_rdata <= {16'h0, ibrd};
          ADDR_FBRD: s_axi_rdata <= {26'h0, fbrd};
          ADDR_LCRH: s_axi_rdata <= {24'h0, lcrh};
          ADDR_CTL: s_axi_rdata <= {22'h0, ctl};
          ADDR_IFLS: s_axi_rdata <= {26'h0, ifls};
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // fractional divider: period is integer part, plus one when the fraction carries
  assign facc_sum = {1'b0, bacc} + {1'b0, lat_div[5:0]};
  always_ff @(posedge aclk) begin
    if (!aresetn || lat_div[21:6] == 16'h0) begin
      bcnt <= 16'h0;
      bacc <= 6'h0;
      tick <= 1'b0;
    end else if (bcnt <= 16'h1) begin
      tick <= 1'b1;
      bacc <= facc_sum[5:0];
      bcnt <= lat_div[21:6] + {15'h0, facc_sum[6]};
    end else begin
      tick <= 1'b0;
      bcnt <= bcnt - 16'h1;
    end
  end

  // low-power pulse clock: 0 divides by 256, n by n
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpcnt <= 8'h0;
      lp_tick <= 1'b0;
    end else begin
      lp_tick <= lpcnt == 8'h0;
      lpcnt <= lpcnt == 8'h0 ? lpdiv - 8'h1 : lpcnt - 8'h1;
    end
  end

  assign eff_depth = lat_lcrh[LCRH_FEN] ? (AW+1)'(FIFO_DEPTH) : (AW+1)'(1);
  assign tx_full = tx_count >= eff_depth;
  assign rx_full = rx_count >= eff_depth;
  assign tx_push = wr_fire && aw_addr == ADDR_W'(ADDR_DATA) && w_strb[0] && !tx_full;
  assign rx_pop = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(ADDR_DATA) &&
    rx_count != '0;
  // no frame starts before a divisor is latched, else the start bit would never end
  assign tx_pop = tx_state == TX_IDLE && tx_count != '0 && ctl[CTL_EN] && ctl[CTL_TXE] &&
    lat_div[21:6] != 16'h0;
  assign busy = tx_count != '0 || tx_state != TX_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= w_data[7:0];
        tx_wp <= tx_wp + AW'(1);
      end
      if (tx_pop) tx_rp <= tx_rp + AW'(1);
      tx_count <= tx_count + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // full fifo drops the new character and marks the next stored one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_count <= '0;
      oe_pend <= 1'b0;
    end else begin
      if (rx_push && !rx_full) begin
        rx_mem[rx_wp] <= {oe_pend, rx_entry[10:0]};
        rx_wp <= rx_wp + AW'(1);
        oe_pend <= 1'b0;
      end else if (rx_push) begin
        oe_pend <= 1'b1;
      end
      if (rx_pop) rx_rp <= rx_rp + AW'(1);
      rx_count <= rx_count + (AW+1)'(rx_push && !rx_full) - (AW+1)'(rx_pop);
    end
  end

  // status of the last read character; overrun set wins over a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsr <= 4'h0;
    end else begin
      if (rx_pop) rsr <= rx_mem[rx_rp][ENT_OE:ENT_FE];
      else if (wr_fire && aw_addr == ADDR_W'(ADDR_RSR)) rsr <= 4'h0;
      if (rx_push && rx_full) rsr[ENT_OE - ENT_FE] <= 1'b1;
    end
  end

  // transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h0;
      tx_bit <= 3'h0;
      tx_tk <= 4'h0;
      tx_par <= 1'b0;
      tx_second <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_state <= TX_START;
            tx_shift <= tx_mem[tx_rp];
            tx_par <= par_bit(tx_mem[tx_rp], lat_lcrh[LCRH_WLEN +: 2], lat_lcrh[LCRH_EPS],
              lat_lcrh[LCRH_SPS]);
            tx_tk <= 4'h0;
            tx_bit <= 3'h0;
            tx_second <= 1'b0;
          end
        end
        default: begin
          // once started a character always completes, even if disabled
          if (tick) begin
            tx_tk <= tx_tk + 4'h1;
            if (tx_tk == LAST_TICK) begin
              case (tx_state)
                TX_START: tx_state <= TX_DATA;
                TX_DATA: begin
                  tx_shift <= tx_shift >> 1;
                  tx_bit <= tx_bit + 3'h1;
                  if (tx_bit == 3'h4 + {1'b0, lat_lcrh[LCRH_WLEN +: 2]}) begin
                    tx_state <= lat_lcrh[LCRH_PEN] ? TX_PAR : TX_STOP;
                  end
                end
                TX_PAR: tx_state <= TX_STOP;
                TX_STOP: begin
                  if (lat_lcrh[LCRH_STP2] && !tx_second) tx_second <= 1'b1;
                  else tx_state <= TX_IDLE;
                end
                default: tx_state <= TX_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    case (tx_state)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = tx_shift[0];
      TX_PAR: tx_line = tx_par;
      default: tx_line = 1'b1;
    endcase
  end

  // infrared encoder: high pulse for each zero bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_lp_cnt <= 2'h0;
    end else if (tx_pop || (tick && tx_tk == LAST_TICK)) begin
      ir_lp_cnt <= SIR_LP_PULSE;
    end else if (lp_tick && ir_lp_cnt != 2'h0) begin
      ir_lp_cnt <= ir_lp_cnt - 2'h1;
    end
  end
  assign ir_pulse = !tx_line && (ctl[CTL_SIRLP] ? ir_lp_cnt != 2'h0 : tx_tk < SIR_PULSE_TICKS);

  always_ff @(posedge aclk) begin
    if (!aresetn) serial_out <= 1'b1;
    else if (lat_lcrh[LCRH_BRK]) serial_out <= 1'b0;
    else if (ctl[CTL_SIR]) serial_out <= ir_pulse;
    else serial_out <= tx_line;
  end

  // receive input: synchroniser, then infrared decoder stretching low pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_in;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) sir_hold <= 4'h0;
    else if (!rx_sync) sir_hold <= LAST_TICK;
    else if (tick && sir_hold != 4'h0) sir_hold <= sir_hold - 4'h1;
  end
  assign rx_line = ctl[CTL_SIR] ? rx_sync && sir_hold == 4'h0 : rx_sync;

  // receiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_tk <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h0;
      rx_pe <= 1'b0;
      rx_anyone <= 1'b0;
      rx_push <= 1'b0;
      rx_entry <= 12'h0;
    end else begin
      rx_push <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          // half duplex in infrared mode: no reception starts while sending
          if (ctl[CTL_EN] && ctl[CTL_RXE] && !rx_line &&
              !(ctl[CTL_SIR] && tx_state != TX_IDLE)) begin
            rx_state <= RX_START;
            rx_tk <= 4'h0;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_tk <= rx_tk + 4'h1;
            if (rx_tk == START_SAMPLE) begin
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
              rx_tk <= 4'h0;
              rx_bit <= 3'h0;
              rx_shift <= 8'h0;
              rx_anyone <= 1'b0;
              rx_pe <= 1'b0;
            end
          end
        end
        RX_WAITHI: if (rx_line) rx_state <= RX_IDLE;
        default: begin
          if (tick) begin
            rx_tk <= rx_tk + 4'h1;
            if (rx_tk == LAST_TICK) begin
              rx_anyone <= rx_anyone | rx_line;
              case (rx_state)
                RX_DATA: begin
                  rx_shift[rx_bit] <= rx_line;
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h4 + {1'b0, lat_lcrh[LCRH_WLEN +: 2]}) begin
                    rx_state <= lat_lcrh[LCRH_PEN] ? RX_PAR : RX_STOP;
                  end
                end
                RX_PAR: begin
                  rx_pe <= rx_line != par_bit(rx_shift, lat_lcrh[LCRH_WLEN +: 2],
                    lat_lcrh[LCRH_EPS], lat_lcrh[LCRH_SPS]);
                  rx_state <= RX_STOP;
                end
                default: begin
                  rx_push <= 1'b1;
                  rx_entry <= {1'b0, !rx_line && !rx_anyone, rx_pe, !rx_line, rx_shift};
                  rx_state <= (!rx_line && !rx_anyone) ? RX_WAITHI : RX_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  property p_busy_tx;
    @(posedge aclk) disable iff (!aresetn) tx_count != '0 |-> busy ##1 busy;
  endproperty
  a_busy_tx: assert property (p_busy_tx) else $error("busy low while tx work pending");

  property p_false_start;
    @(posedge aclk) disable iff (!aresetn)
      rx_state == RX_START && tick && rx_tk == START_SAMPLE && rx_line |=> rx_state == RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start kept");

  property p_div_latch;
    @(posedge aclk) disable iff (!aresetn)
      !(wr_fire && aw_addr == ADDR_W'(ADDR_LCRH)) |=> $stable(lat_div) && $stable(lat_lcrh);
  endproperty
  a_div_latch: assert property (p_div_latch) else $error("divisor latch changed");

  property p_enables_reset;
    @(posedge aclk) $rose(aresetn) |-> ctl[CTL_TXE] && ctl[CTL_RXE] && !lat_lcrh[LCRH_FEN];
  endproperty
  a_enables_reset: assert property (p_enables_reset) else $error("bad reset enables");

  property p_start_low;
    @(posedge aclk) disable iff (!aresetn)
      tx_state == TX_START && !lat_lcrh[LCRH_BRK] && !ctl[CTL_SIR] |=> !serial_out;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_break_low;
    @(posedge aclk) disable iff (!aresetn)
      lat_lcrh[LCRH_BRK] ##1 lat_lcrh[LCRH_BRK] |-> !serial_out;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not driven low");

  property p_overrun;
    @(posedge aclk) disable iff (!aresetn)
      rx_push && rx_full && !rx_pop |=> rx_count == $past(rx_count) && oe_pend && rsr[3];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_tx_start;
    @(posedge aclk) disable iff (!aresetn)
      tx_state == TX_IDLE && tx_count != '0 && ctl[CTL_EN] && ctl[CTL_TXE] && lat_div[21:6] != '0
      |=> tx_state == TX_START && tx_count == $past(tx_count) + (AW+1)'($past(tx_push)) - 1'b1;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("frame did not start");

  property p_framing;
    @(posedge aclk) disable iff (!aresetn)
      rx_state == RX_STOP && tick && rx_tk == LAST_TICK
      |=> rx_push && rx_entry[ENT_FE] == !$past(rx_line);
  endproperty
  a_framing: assert property (p_framing) else $error("framing status wrong");
endmodule
`default_nettype wire

/* bench/ast_peer.sv */
`default_nettype none
module ast_peer (
  input wire logic aclk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial rx_line = 1'b1;
  // captures 8n1 frames, sampling each bit at its middle
  initial begin : cap
    logic [7:0] b;
    forever begin
      @(negedge tx_line);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge aclk);
        b[i] = tx_line;
      end
      got.push_back(b);
      repeat (16) @(posedge aclk);
    end
  end
  // sends one 8n1 frame, stop level chosen by caller
  task send(input logic [7:0] d, input logic stp);
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rx_line <= (i == 0) ? 1'b0 : (i == 9) ? stp : d[i-1];
      repeat (15) @(posedge aclk);
    end
    @(posedge aclk);
    rx_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* bench/ast_uart_tb.sv */
`default_nettype none
module ast_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ast_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sin, sout;
  logic awready, wready, bvalid, arready, rvalid;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic [7:0] s, c;
  int err_total, num_checks;
  ast_uart i_ast_uart (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_in(sin), .serial_out(sout));
  ast_peer i_ast_peer (.aclk(aclk), .tx_line(sout), .rx_line(sin));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp; bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [5:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata; r = rresp; rready <= 1'b0;
    @(posedge aclk);
  endtask
  task wait_got(input int n);
    while (i_ast_peer.got.size() < n) @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 6'h00; araddr = 6'h00; wdata = 32'h0; s = 8'h58;
    err_total = 0; num_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTL); chk(v, 32'h300);
    rd(ADDR_LCRH); chk(v, 32'h0);
    rd(6'h3c); chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(6'h3c, 32'h0); chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(ADDR_IBRD, 32'h1); wr(ADDR_CTL, 32'h301); wr(ADDR_DATA, 32'h33);
    repeat (100) @(posedge aclk);
    chk(i_ast_peer.got.size(), 0);
    wr(ADDR_CTL, 32'h300); wr(ADDR_LCRH, 32'h70); wr(ADDR_CTL, 32'h301);
    wait_got(1); chk(i_ast_peer.got[0], 32'h33);
    for (int k = 1; k < 5; k++) begin
      s = lfsr(s); wr(ADDR_DATA, {24'h0, s});
      rd(ADDR_FLAG); chk({31'h0, v[FLAG_BUSY]}, 32'h1);
      wait_got(k + 1); chk(i_ast_peer.got[k], {24'h0, s});
      s = lfsr(s); i_ast_peer.send(s, 1'b1);
      rd(ADDR_DATA); chk(v, {24'h0, s});
    end
    repeat (40) @(posedge aclk);
    rd(ADDR_FLAG); chk({31'h0, v[FLAG_BUSY]}, 32'h0);
    i_ast_peer.send(8'h5a, 1'b0);
    rd(ADDR_DATA); chk(v, 32'h15a);
    wr(ADDR_DATA, 32'ha5); wr(ADDR_CTL, 32'h300);
    rd(ADDR_FLAG); chk({31'h0, v[FLAG_BUSY]}, 32'h1);
    wait_got(6); chk(i_ast_peer.got[5], 32'ha5);
    wr(ADDR_LCRH, 32'h60); wr(ADDR_RSR, 32'h0); wr(ADDR_CTL, 32'h301);
    c = lfsr(s); s = lfsr(c);
    i_ast_peer.send(c, 1'b1); i_ast_peer.send(s, 1'b1);
    rd(ADDR_RSR); chk(v, 32'h8);
    rd(ADDR_DATA); chk(v, {24'h0, c});
    i_ast_peer.send(8'h00, 1'b0);
    rd(ADDR_DATA); chk(v, 32'hd00);
    wr(ADDR_CTL, 32'h300); wr(ADDR_LCRH, 32'h61);
    chk({31'h0, sout}, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
